// ==== verilog/amd_pkg.sv ====
package amd_pkg;

  // ********************************************************************
  // Prebyte codes
  // ********************************************************************
  localparam logic [7:0] PREBYTE_NONE          = 8'h00;
  localparam logic [7:0] PREBYTE_SWAP_TO_Y     = 8'h90;
  localparam logic [7:0] PREBYTE_INDIRECT_Y    = 8'h91;
  localparam logic [7:0] PREBYTE_MAKE_INDIRECT = 8'h92;

  // ********************************************************************
  // Opcode layout: upper nibble is the addressing class, lower the operation
  // ********************************************************************
  localparam int         OPC_CLASS_MSB     = 7;
  localparam int         OPC_CLASS_LSB     = 4;
  localparam int         OPC_SHORT_ONLY    = 3;
  localparam logic [3:0] CLS_INH           = 4'h0;
  localparam logic [3:0] CLS_IMM           = 4'h1;
  localparam logic [3:0] CLS_DIR_S         = 4'h2;
  localparam logic [3:0] CLS_DIR_L         = 4'h3;
  localparam logic [3:0] CLS_IX0           = 4'h4;
  localparam logic [3:0] CLS_IX1           = 4'h5;
  localparam logic [3:0] CLS_IX2           = 4'h6;
  localparam logic [3:0] CLS_REL           = 4'h7;
  localparam logic [3:0] CLS_BIT           = 4'h8;
  localparam logic [3:0] CLS_BTJ           = 4'h9;
  localparam logic [3:0] OP_MASK_SET_INSTR = 4'hE;
  localparam logic [3:0] OP_MASK_RESET_INSTR = 4'hF;

  // ********************************************************************
  // Interrupt mask levels and other values
  // ********************************************************************
  localparam logic [1:0]  MASK_LVL_SET   = 2'h3;
  localparam logic [1:0]  MASK_LVL_RESET = 2'h0;
  localparam logic [1:0]  MASK_LVL_RST   = 2'h3;
  localparam logic [7:0]  PAGE_ZERO      = 8'h00;
  localparam logic [7:0]  REL_OFF_BAD    = 8'h80;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [15:0] ADDR_STEP      = 16'h0001;
  localparam logic [2:0]  LEN_STEP       = 3'h1;
  localparam logic [1:0]  ARGS_NONE      = 2'h0;
  localparam logic [1:0]  ARGS_TWO       = 2'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC  = 3'b001,
    ST_ARG1 = 3'b011,
    ST_ARG2 = 3'b010,
    ST_PTR1 = 3'b110,
    ST_PTR2 = 3'b111,
    ST_CALC = 3'b101
  } amd_state_t;

  typedef enum logic [4:0] {
    M_INH   = 5'h00,
    M_IMM   = 5'h01,
    M_DIR_S = 5'h02,
    M_DIR_L = 5'h03,
    M_IX0   = 5'h04,
    M_IX1   = 5'h05,
    M_IX2   = 5'h06,
    M_IND_S = 5'h07,
    M_IND_L = 5'h08,
    M_IIX_S = 5'h09,
    M_IIX_L = 5'h0A,
    M_REL_D = 5'h0B,
    M_REL_I = 5'h0C,
    M_BIT_D = 5'h0D,
    M_BIT_I = 5'h0E,
    M_BTJ_D = 5'h0F,
    M_BTJ_I = 5'h10
  } amd_mode_t;

endpackage

// ==== verilog/amd_addr_add.sv ====
module amd_addr_add #(
  parameter bit SIGNED_OFF = 1'b0
) (
  // Operands
  input  wire logic [15:0] base,
  input  wire logic [7:0]  off,
  // Result
  output logic      [15:0] sum
);
  import amd_pkg::*;

  logic [15:0] ext;

  // ********************************************************************
  // Full-width add: a page-zero base plus an index carries into bit 8
  // ********************************************************************
  always_comb begin
    ext = SIGNED_OFF ? {{8{off[7]}}, off} : {PAGE_ZERO, off};
    sum = base + ext;
  end

endmodule

// ==== verilog/amd_decoder.sv ====
module amd_decoder (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // Decode request
  input  wire logic                start,
  input  wire logic [15:0]         pc_in,
  input  wire logic [7:0]          x_in,
  input  wire logic [7:0]          y_in,
  // Program memory
  output logic                     mem_rd,
  output logic      [15:0]         mem_addr,
  input  wire logic                mem_ack,
  input  wire logic [7:0]          mem_rdata,
  // Decode result
  output logic                     ready,
  output logic                     done,
  output logic                     illegal,
  output amd_pkg::amd_mode_t       mode,
  output logic      [7:0]          opcode,
  output logic      [2:0]          length,
  output logic      [15:0]         ea,
  output logic      [7:0]          operand,
  output logic                     use_y,
  output logic      [15:0]         branch_target,
  output logic      [1:0]          mask_level
);
  import amd_pkg::*;

  typedef struct packed {
    amd_state_t  state;
    logic [15:0] pc;
    logic [7:0]  pre;
    logic [7:0]  opcode;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  ptr_hi;
    logic [7:0]  ptr_lo;
    logic [2:0]  len;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic        ready;
    logic        done;
    logic        illegal;
    amd_mode_t   mode;
    logic [15:0] ea;
    logic [7:0]  operand;
    logic        use_y;
    logic [15:0] target;
    logic [1:0]  mask;
  } amd_st_t;

  amd_st_t     st_reg;
  amd_st_t     st_next;
  logic [3:0]  cls;
  logic        ind;
  logic [15:0] base;
  logic [7:0]  idx_off;
  logic [7:0]  rel_off;
  logic        is_rel;
  logic [15:0] ea_sum;
  logic [15:0] rel_sum;

  // ********************************************************************
  // Decode helpers
  // ********************************************************************
  function automatic logic is_prebyte(input logic [7:0] b);
    is_prebyte = (b == PREBYTE_SWAP_TO_Y) || (b == PREBYTE_INDIRECT_Y) || (b == PREBYTE_MAKE_INDIRECT);
  endfunction

  function automatic logic pre_ind(input logic [7:0] pre);
    pre_ind = (pre == PREBYTE_MAKE_INDIRECT) || (pre == PREBYTE_INDIRECT_Y);
  endfunction

  // Bytes following the opcode
  function automatic logic [1:0] arg_count(input logic [7:0] pre, input logic [7:0] op);
    logic [3:0] c;
    c = op[OPC_CLASS_MSB:OPC_CLASS_LSB];
    case (c)
      CLS_INH, CLS_IX0:                      arg_count = 2'h0;
      CLS_IMM, CLS_DIR_S, CLS_IX1, CLS_BIT:  arg_count = 2'h1;
      CLS_REL:                               arg_count = 2'h1;
      CLS_DIR_L, CLS_IX2:                    arg_count = pre_ind(pre) ? 2'h1 : 2'h2;
      CLS_BTJ:                               arg_count = 2'h2;
      default:                               arg_count = 2'h0;
    endcase
  endfunction

  function automatic logic legal(input logic [7:0] pre, input logic [7:0] op);
    logic [3:0] c;
    logic       long_form;
    c         = op[OPC_CLASS_MSB:OPC_CLASS_LSB];
    long_form = (c == CLS_DIR_L) || (c == CLS_IX2);
    if (c > CLS_BTJ) begin
      legal = 1'b0;
    end else begin
      case (pre)
        PREBYTE_NONE:          legal = !(op[OPC_SHORT_ONLY] && long_form);
        PREBYTE_SWAP_TO_Y:     legal = (c <= CLS_IX2) && !(op[OPC_SHORT_ONLY] && long_form);
        PREBYTE_MAKE_INDIRECT: legal = (c != CLS_INH) && (c != CLS_IMM) && (c != CLS_IX0);
        PREBYTE_INDIRECT_Y:    legal = (c == CLS_IX1) || (c == CLS_IX2);
        default:               legal = 1'b0;
      endcase
    end
  endfunction

  function automatic amd_mode_t mode_of(input logic [3:0] c, input logic i);
    case (c)
      CLS_IMM:   mode_of = M_IMM;
      CLS_DIR_S: mode_of = i ? M_IND_S : M_DIR_S;
      CLS_DIR_L: mode_of = i ? M_IND_L : M_DIR_L;
      CLS_IX0:   mode_of = M_IX0;
      CLS_IX1:   mode_of = i ? M_IIX_S : M_IX1;
      CLS_IX2:   mode_of = i ? M_IIX_L : M_IX2;
      CLS_REL:   mode_of = i ? M_REL_I : M_REL_D;
      CLS_BIT:   mode_of = i ? M_BIT_I : M_BIT_D;
      CLS_BTJ:   mode_of = i ? M_BTJ_I : M_BTJ_D;
      default:   mode_of = M_INH;
    endcase
  endfunction

  // ********************************************************************
  // Address formation
  // ********************************************************************
  always_comb begin
    cls     = st_reg.opcode[OPC_CLASS_MSB:OPC_CLASS_LSB];
    ind     = pre_ind(st_reg.pre);
    base    = 16'h0000;
    idx_off = BYTE_ZERO;
    rel_off = BYTE_ZERO;
    is_rel  = (cls == CLS_REL) || (cls == CLS_BTJ);
    case (cls)
      CLS_DIR_S, CLS_IX1, CLS_BIT, CLS_BTJ: begin
        base = ind ? {PAGE_ZERO, st_reg.ptr_hi} : {PAGE_ZERO, st_reg.b1};
      end
      CLS_DIR_L, CLS_IX2: begin
        base = ind ? {st_reg.ptr_hi, st_reg.ptr_lo} : {st_reg.b1, st_reg.b2};
      end
      default: begin
        base = 16'h0000;
      end
    endcase
    if ((cls == CLS_IX0) || (cls == CLS_IX1) || (cls == CLS_IX2)) begin
      idx_off = st_reg.use_y ? y_in : x_in;
    end
    if (cls == CLS_REL) begin
      rel_off = ind ? st_reg.ptr_hi : st_reg.b1;
    end else if (cls == CLS_BTJ) begin
      rel_off = st_reg.b2;
    end
  end

  amd_addr_add #(
    .SIGNED_OFF (1'b0)
  ) u_ea_add (
    .base (base),
    .off  (idx_off),
    .sum  (ea_sum)
  );

  amd_addr_add #(
    .SIGNED_OFF (1'b1)
  ) u_rel_add (
    .base (st_reg.pc),
    .off  (rel_off),
    .sum  (rel_sum)
  );

  // ********************************************************************
  // Fetch and decode sequence
  // ********************************************************************
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      ST_IDLE: begin
        if (start) begin
          st_next.state    = ST_OPC;
          st_next.pc       = pc_in;
          st_next.pre      = PREBYTE_NONE;
          st_next.len      = 3'h0;
          st_next.illegal  = 1'b0;
          st_next.use_y    = 1'b0;
          st_next.b1       = BYTE_ZERO;
          st_next.b2       = BYTE_ZERO;
          st_next.ptr_hi   = BYTE_ZERO;
          st_next.ptr_lo   = BYTE_ZERO;
          st_next.mem_rd   = 1'b1;
          st_next.mem_addr = pc_in;
          st_next.ready    = 1'b0;
        end
      end
      ST_OPC: begin
        if (mem_ack) begin
          st_next.pc  = st_reg.pc + ADDR_STEP;
          st_next.len = st_reg.len + LEN_STEP;
          if (is_prebyte(mem_rdata) && (st_reg.pre != PREBYTE_NONE)) begin
            st_next.illegal = 1'b1;
            st_next.opcode  = mem_rdata;
            st_next.mem_rd  = 1'b0;
            st_next.state   = ST_CALC;
          end else if (is_prebyte(mem_rdata)) begin
            st_next.pre      = mem_rdata;
            st_next.mem_addr = st_reg.pc + ADDR_STEP;
          end else begin
            st_next.opcode = mem_rdata;
            st_next.use_y  = (st_reg.pre == PREBYTE_SWAP_TO_Y) || (st_reg.pre == PREBYTE_INDIRECT_Y);
            if (!legal(st_reg.pre, mem_rdata)) begin
              st_next.illegal = 1'b1;
              st_next.mem_rd  = 1'b0;
              st_next.state   = ST_CALC;
            end else if (arg_count(st_reg.pre, mem_rdata) != ARGS_NONE) begin
              st_next.mem_addr = st_reg.pc + ADDR_STEP;
              st_next.state    = ST_ARG1;
            end else begin
              st_next.mem_rd = 1'b0;
              st_next.state  = ST_CALC;
            end
          end
        end
      end
      ST_ARG1: begin
        if (mem_ack) begin
          st_next.b1  = mem_rdata;
          st_next.pc  = st_reg.pc + ADDR_STEP;
          st_next.len = st_reg.len + LEN_STEP;
          if (arg_count(st_reg.pre, st_reg.opcode) == ARGS_TWO) begin
            st_next.mem_addr = st_reg.pc + ADDR_STEP;
            st_next.state    = ST_ARG2;
          end else if (pre_ind(st_reg.pre)) begin
            st_next.mem_addr = {PAGE_ZERO, mem_rdata};
            st_next.state    = ST_PTR1;
          end else begin
            st_next.mem_rd = 1'b0;
            st_next.state  = ST_CALC;
          end
        end
      end
      ST_ARG2: begin
        if (mem_ack) begin
          st_next.b2  = mem_rdata;
          st_next.pc  = st_reg.pc + ADDR_STEP;
          st_next.len = st_reg.len + LEN_STEP;
          if (pre_ind(st_reg.pre)) begin
            st_next.mem_addr = {PAGE_ZERO, st_reg.b1};
            st_next.state    = ST_PTR1;
          end else begin
            st_next.mem_rd = 1'b0;
            st_next.state  = ST_CALC;
          end
        end
      end
      ST_PTR1: begin
        if (mem_ack) begin
          st_next.ptr_hi = mem_rdata;
          if ((st_reg.opcode[OPC_CLASS_MSB:OPC_CLASS_LSB] == CLS_DIR_L) ||
              (st_reg.opcode[OPC_CLASS_MSB:OPC_CLASS_LSB] == CLS_IX2)) begin
            st_next.mem_addr = {PAGE_ZERO, st_reg.b1} + ADDR_STEP;
            st_next.state    = ST_PTR2;
          end else begin
            st_next.mem_rd = 1'b0;
            st_next.state  = ST_CALC;
          end
        end
      end
      ST_PTR2: begin
        if (mem_ack) begin
          st_next.ptr_lo = mem_rdata;
          st_next.mem_rd = 1'b0;
          st_next.state  = ST_CALC;
        end
      end
      ST_CALC: begin
        st_next.state   = ST_IDLE;
        st_next.ready   = 1'b1;
        st_next.done    = 1'b1;
        st_next.mode    = mode_of(cls, ind);
        st_next.ea      = ea_sum;
        st_next.operand = (cls == CLS_IMM) ? st_reg.b1 : BYTE_ZERO;
        st_next.target  = is_rel ? rel_sum : st_reg.pc;
        st_next.illegal = st_reg.illegal || (is_rel && (rel_off == REL_OFF_BAD));
        if (!st_next.illegal && (cls == CLS_INH)) begin
          if (st_reg.opcode[3:0] == OP_MASK_SET_INSTR) begin
            st_next.mask = MASK_LVL_SET;
          end else if (st_reg.opcode[3:0] == OP_MASK_RESET_INSTR) begin
            st_next.mask = MASK_LVL_RESET;
          end
        end
      end
      default: begin
        st_next.state  = ST_IDLE;
        st_next.mem_rd = 1'b0;
        st_next.ready  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg       <= '0;
      st_reg.ready <= 1'b1;
      st_reg.mask  <= MASK_LVL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign mem_rd        = st_reg.mem_rd;
  assign mem_addr      = st_reg.mem_addr;
  assign ready         = st_reg.ready;
  assign done          = st_reg.done;
  assign illegal       = st_reg.illegal;
  assign mode          = st_reg.mode;
  assign opcode        = st_reg.opcode;
  assign length        = st_reg.len;
  assign ea            = st_reg.ea;
  assign operand       = st_reg.operand;
  assign use_y         = st_reg.use_y;
  assign branch_target = st_reg.target;
  assign mask_level    = st_reg.mask;

endmodule

// ==== dv/amd_decoder_props.sv ====
module amd_decoder_props
  import amd_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // Decode request
  input wire logic               start,
  input wire logic [15:0]        pc_in,
  input wire logic [7:0]         x_in,
  input wire logic [7:0]         y_in,
  // Program memory
  input wire logic               mem_rd,
  input wire logic [15:0]        mem_addr,
  input wire logic               mem_ack,
  input wire logic [7:0]         mem_rdata,
  // Decode result
  input wire logic               ready,
  input wire logic               done,
  input wire logic               illegal,
  input wire amd_pkg::amd_mode_t mode,
  input wire logic [7:0]         opcode,
  input wire logic [2:0]         length,
  input wire logic [15:0]        ea,
  input wire logic [7:0]         operand,
  input wire logic               use_y,
  input wire logic [15:0]        branch_target,
  input wire logic [1:0]         mask_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fin_ok;
  assign fin_ok = done && !illegal;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ********
  // Decode request steps
  // ********
  sequence s_take;
    start && ready;
  endsequence
  sequence s_finish;
    ##[3:80] done;
  endsequence
  take_to_done_a: assert property (s_take |-> s_finish) else $error("Decode never finished");
  done_not_early_a: assert property (s_take |=> !done [*2]) else $error("Done came too early");
  done_pulse_a: assert property (done |=> !done) else $error("Done longer than one cycle");
  idle_quiet_a: assert property (ready && !start |=> !done && !mem_rd) else $error("Activity while idle");
  mem_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr)) else $error("Read dropped");
  // ********
  // Result relations
  // ********
  len_range_a: assert property (fin_ok |-> length inside {[3'h1:3'h4]}) else $error("Length out of range");
  inh_len_a: assert property (fin_ok && mode == M_INH |-> length == (use_y ? 3'h2 : 3'h1))
    else $error("Inherent length wrong");
  imm_len_a: assert property (fin_ok && mode == M_IMM |-> length == (use_y ? 3'h3 : 3'h2))
    else $error("Immediate length wrong");
  page_zero_a: assert property (fin_ok && mode inside {M_DIR_S, M_IX0, M_IND_S, M_BIT_D, M_BIT_I, M_BTJ_D,
    M_BTJ_I} |-> ea[15:8] == 8'h00) else $error("Address left page zero");
  nine_bit_a: assert property (fin_ok && mode inside {M_IX1, M_IIX_S} |-> ea <= 16'h01FE)
    else $error("Short indexed sum too large");
  short_only_a: assert property (fin_ok && mode inside {M_DIR_L, M_IX2} |-> !opcode[OPC_SHORT_ONLY])
    else $error("Short-only operation in long form");
  bad_class_a: assert property (done && opcode[7:4] > CLS_BTJ |-> illegal) else $error("Bad class accepted");
  mask_set_a: assert property (fin_ok && mode == M_INH && opcode[3:1] == 3'h7
    |-> mask_level == (opcode[0] ? MASK_LVL_RESET : MASK_LVL_SET)) else $error("Mask level wrong");
  mask_hold_a: assert property (!done && $past(rst_b) |-> $stable(mask_level)) else $error("Mask moved");
  use_y_pre_a: assert property (fin_ok && use_y |-> length >= 3'h2) else $error("Y without prebyte");
endmodule

bind amd_decoder amd_decoder_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .start(start), .pc_in(pc_in),
  .x_in(x_in), .y_in(y_in), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .ready(ready), .done(done), .illegal(illegal), .mode(mode), .opcode(opcode), .length(length), .ea(ea),
  .operand(operand), .use_y(use_y), .branch_target(branch_target), .mask_level(mask_level));

// ==== dv/amd_mem_model.sv ====
module amd_mem_model (
  // Clock
  input  wire logic        clk_sys,
  // Read request
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic        slow,
  // Answer
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:65535];
  int         waits;
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 8'h5A;
    waits     = 0;
  end
  // Slow mode holds each read for two extra cycles; idle data keeps toggling
  always @(negedge clk_sys) begin
    if (mem_rd === 1'b1 && waits >= (slow ? 2 : 0)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= store[mem_addr];
      waits     <= 0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      waits     <= (mem_rd === 1'b1) ? waits + 1 : 0;
    end
  end
endmodule

// ==== dv/test_cpu_addressing_mode_decoder.sv ====
module test_cpu_addressing_mode_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import amd_pkg::*;
  typedef struct packed {
    logic        il;
    amd_mode_t   md;
    logic [2:0]  ln;
    logic [15:0] ea;
    logic [7:0]  op;
    logic        uy;
    logic [15:0] bt;
    logic [1:0]  ml;
    logic [7:0]  oc;
  } amd_exp_t;
  logic        clk_sys, rst_b, start, mem_rd, mem_ack, ready, done, illegal, use_y, slow;
  logic [15:0] pc_in, mem_addr, ea, branch_target, pc;
  logic [7:0]  x_in, y_in, mem_rdata, opcode, operand, b1, b2, p1, p2;
  logic [2:0]  length;
  logic [1:0]  mask_level, cur_ml;
  logic [31:0] lfsr_state;
  amd_mode_t   mode;
  amd_exp_t    exp_q[$];
  amd_exp_t    ce;
  int          n_fail, total_checks;

  amd_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .start(start), .pc_in(pc_in), .x_in(x_in), .y_in(y_in),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ready(ready), .done(done),
    .illegal(illegal), .mode(mode), .opcode(opcode), .length(length), .ea(ea), .operand(operand), .use_y(use_y),
    .branch_target(branch_target), .mask_level(mask_level));
  amd_mem_model mem (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_addr(mem_addr), .slow(slow), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic amd_exp_t mk(logic il, amd_mode_t md, logic [2:0] ln, logic [15:0] ea_e,
                                  logic [7:0] op_e, logic uy, logic [7:0] off);
    return '{il, md, ln, ea_e, op_e, uy, pc + {13'h0, ln} + {{8{off[7]}}, off}, cur_ml, 8'h00};
  endfunction
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Fresh operands and a pointer planted in page zero
  task automatic sh();
    lfsr_state = lfsr(lfsr(lfsr_state));
    {b1, b2, p1, p2} = lfsr_state;
    if (b2 == 8'h80) b2 = 8'h7F;
    if (p1 == 8'h80) p1 = 8'h81;
    lfsr_state = lfsr(lfsr(lfsr_state));
    {pc, x_in, y_in} = {4'h4, lfsr_state[27:0]};
    mem.store[{8'h00, b1}] = p1;
    mem.store[{8'h00, b1} + 16'h1] = p2;
  endtask
  task automatic issue(input logic [31:0] code, input amd_exp_t e);
    int       k;
    amd_exp_t ee;
    for (int i = 0; i < 4; i++) begin
      mem.store[pc + 16'(i)] = code[31 - 8 * i -: 8];
    end
    // Opcode is the byte after a leading prebyte, else the first byte
    ee    = e;
    ee.oc = (code[31:24] inside {PREBYTE_SWAP_TO_Y, PREBYTE_INDIRECT_Y, PREBYTE_MAKE_INDIRECT}) ?
            code[23:16] : code[31:24];
    exp_q.push_back(ee);
    start = 1'b1;
    pc_in = pc;
    // Second cycle of start falls while busy and must be ignored
    repeat (2) @(negedge clk_sys);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1) begin
      @(negedge clk_sys);
      k++;
      if (k > 80) begin
        n_fail++;
        $display("MISMATCH done expected 1 seen timeout");
        give_verdict();
      end
    end
    $display("Test %h finished", code);
  endtask

  // ********
  // Result monitor
  // ********
  always @(negedge clk_sys) begin
    if (rst_b === 1'b1 && done === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp("spurious_done", 16'h0, 16'h1);
      end else begin
        ce = exp_q.pop_front();
        cmp("illegal", 16'(ce.il), 16'(illegal));
        cmp("opcode", 16'(ce.oc), 16'(opcode));
        if (!ce.il) begin
          cmp("mode", 16'(ce.md), 16'(mode));
          cmp("length", 16'(ce.ln), 16'(length));
          cmp("ea", ce.ea, ea);
          cmp("operand", 16'(ce.op), 16'(operand));
          cmp("use_y", 16'(ce.uy), 16'(use_y));
          cmp("branch_target", ce.bt, branch_target);
          cmp("mask_level", 16'(ce.ml), 16'(mask_level));
        end
      end
    end
  end

  // ********
  // Scenarios
  // ********
  task automatic run_all();
    logic [31:0] bad [10] = '{32'h38000000, 32'h68000000, 32'hA0000000, 32'hF0000000, 32'h91200000,
                              32'h90700000, 32'h92100000, 32'h90900000, 32'h70800000, 32'h920E0000};
    sh();
    cur_ml = MASK_LVL_RESET;
    issue({8'h0F, 24'h0}, mk('0, M_INH, 3'h1, '0, '0, '0, '0));
    foreach (bad[i]) begin
      issue(bad[i], mk('1, M_INH, '0, '0, '0, '0, '0));
    end
    issue({8'h01, 24'h0}, mk('0, M_INH, 3'h1, '0, '0, '0, '0));
    cur_ml = MASK_LVL_SET;
    issue({8'h0E, 24'h0}, mk('0, M_INH, 3'h1, '0, '0, '0, '0));
    sh(); issue({8'h10, b1, 16'h0}, mk('0, M_IMM, 3'h2, '0, b1, '0, '0));
    sh(); issue({8'h90, 8'h11, b1, 8'h0}, mk('0, M_IMM, 3'h3, '0, b1, '1, '0));
    sh(); issue({8'h90, 8'h01, 16'h0}, mk('0, M_INH, 3'h2, '0, '0, '1, '0));
    sh(); issue({8'h28, b1, 16'h0}, mk('0, M_DIR_S, 3'h2, {8'h0, b1}, '0, '0, '0));
    sh(); issue({8'h30, b1, b2, 8'h0}, mk('0, M_DIR_L, 3'h3, {b1, b2}, '0, '0, '0));
    sh(); issue({8'h40, 24'h0}, mk('0, M_IX0, 3'h1, {8'h0, x_in}, '0, '0, '0));
    sh(); issue({8'h90, 8'h40, 16'h0}, mk('0, M_IX0, 3'h2, {8'h0, y_in}, '0, '1, '0));
    sh(); issue({8'h50, b1, 16'h0}, mk('0, M_IX1, 3'h2, {8'h0, b1} + {8'h0, x_in}, '0, '0, '0));
    x_in = 8'hFF;
    issue({8'h50, 8'hFF, 16'h0}, mk('0, M_IX1, 3'h2, 16'h01FE, '0, '0, '0));
    sh(); issue({8'h60, b1, b2, 8'h0}, mk('0, M_IX2, 3'h3, {b1, b2} + {8'h0, x_in}, '0, '0, '0));
    sh(); issue({8'h90, 8'h60, b1, b2}, mk('0, M_IX2, 3'h4, {b1, b2} + {8'h0, y_in}, '0, '1, '0));
    sh(); issue({8'h92, 8'h20, b1, 8'h0}, mk('0, M_IND_S, 3'h3, {8'h0, p1}, '0, '0, '0));
    sh(); issue({8'h92, 8'h38, b1, 8'h0}, mk('0, M_IND_L, 3'h3, {p1, p2}, '0, '0, '0));
    sh(); issue({8'h92, 8'h50, b1, 8'h0}, mk('0, M_IIX_S, 3'h3, {8'h0, p1} + {8'h0, x_in}, '0, '0, '0));
    sh(); issue({8'h92, 8'h60, b1, 8'h0}, mk('0, M_IIX_L, 3'h3, {p1, p2} + {8'h0, x_in}, '0, '0, '0));
    sh(); issue({8'h91, 8'h50, b1, 8'h0}, mk('0, M_IIX_S, 3'h3, {8'h0, p1} + {8'h0, y_in}, '0, '1, '0));
    sh(); issue({8'h91, 8'h60, b1, 8'h0}, mk('0, M_IIX_L, 3'h3, {p1, p2} + {8'h0, y_in}, '0, '1, '0));
    sh(); issue({8'h70, b2, 16'h0}, mk('0, M_REL_D, 3'h2, '0, '0, '0, b2));
    issue({8'h70, 8'h7F, 16'h0}, mk('0, M_REL_D, 3'h2, '0, '0, '0, 8'h7F));
    issue({8'h70, 8'h81, 16'h0}, mk('0, M_REL_D, 3'h2, '0, '0, '0, 8'h81));
    sh(); issue({8'h92, 8'h70, b1, 8'h0}, mk('0, M_REL_I, 3'h3, '0, '0, '0, p1));
    sh(); issue({8'h80, b1, 16'h0}, mk('0, M_BIT_D, 3'h2, {8'h0, b1}, '0, '0, '0));
    sh(); issue({8'h92, 8'h88, b1, 8'h0}, mk('0, M_BIT_I, 3'h3, {8'h0, p1}, '0, '0, '0));
    sh(); issue({8'h98, b1, b2, 8'h0}, mk('0, M_BTJ_D, 3'h3, {8'h0, b1}, '0, '0, b2));
    sh(); issue({8'h92, 8'h98, b1, b2}, mk('0, M_BTJ_I, 3'h4, {8'h0, p1}, '0, '0, b2));
  endtask

  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    pc_in = 16'h0000;
    pc = 16'h4000;
    x_in = 8'h00;
    y_in = 8'h00;
    slow = 1'b0;
    n_fail = 0;
    total_checks = 0;
    cur_ml = MASK_LVL_RST;
    lfsr_state = 32'h739C6DAB;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    cmp("ready", 16'h1, 16'(ready));
    cmp("mask_level", 16'h3, 16'(mask_level));
    for (int ps = 0; ps < 2; ps++) begin
      slow = ps[0];
      run_all();
    end
    repeat (4) @(negedge clk_sys);
    give_verdict();
  end
endmodule
